/* src/spl_map.svh */
// constants for the stack pointer limit checker
// Summary of operation
// - Working register fifteen serves both as a general register and as the stack pointer.
// - The stack pointer always holds the address of the next free stack word.
// - The stack grows upward: pushes raise the pointer, pops lower it.
// - A push writes at the pointer then adds two; a pop subtracts two then reads there.
// - A call pushes the program counter with its top bit cleared by zero extension.
// - An exception pushes the program counter with the status low byte in its upper part.
// - The stack limit register is not touched by reset and is undefined until written.
// - Bit zero of the stack limit register reads zero once the register has been written.
// - Every address formed through the stack pointer is compared with the stack limit.
// - A push at pointer equal to limit does not trap; the next push beyond it traps.
// - An underflow trap is raised whenever a stack pointer address is below 0800h.
// - The program counter is 23 bits wide within a 24-bit program address.
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH
`define SPL_DATA_W     16
`define SPL_PC_W       23
`define SPL_PADDR_W    24
`define SPL_WORD_STEP  16'h0002
`define SPL_FLOOR      16'h0800
`define SPL_SP_RESET   16'h0800
`define SPL_SP_INDEX   4'hF
`endif

/* src/spl_pkg.sv */
// types for the stack pointer limit checker
package spl_pkg;
   // stack operation requested by the core
   typedef enum logic [2:0] {
      SPL_OP_NONE,
      SPL_OP_PUSH,
      SPL_OP_POP,
      SPL_OP_CALL,
      SPL_OP_EXC,
      SPL_OP_EA
   } spl_op_t;

   // access presented to the memory side
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } spl_mem_t;

   // register file write port of the core
   typedef struct packed {
      logic        we;
      logic [3:0]  idx;
      logic [15:0] data;
   } spl_wreg_t;
endpackage

/* src/spl_cmp.sv */
// stack address comparator against limit and floor
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_cmp
(
   // address under test
   input  wire logic [15:0] i_addr,
   input  wire logic        i_check,
   // limit value
   input  wire logic [15:0] i_limit,
   // results
   output logic             o_over,
   output logic             o_under
);
   assign o_over  = i_check && (i_addr > i_limit);
   assign o_under = i_check && (i_addr < `SPL_FLOOR);
endmodule

/* src/spl_core.sv */
// stack pointer, push/pop sequencing and stack error detection
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_core
   import spl_pkg::*;
(
   // clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   // stack operation request
   input  wire spl_pkg::spl_op_t     i_op,
   input  wire logic [15:0]          i_push_data,
   input  wire logic [22:0]          i_pc,
   input  wire logic [7:0]           i_status_low_byte,
   input  wire logic [15:0]          i_ea,
   // register writes from core
   input  wire spl_pkg::spl_wreg_t   i_wreg,
   input  wire logic                 i_limit_we,
   input  wire logic [15:0]          i_limit_data,
   input  wire logic                 i_err_clr,
   // results
   output spl_pkg::spl_mem_t         o_mem,
   output logic [15:0]               o_stack_pointer_reg,
   output logic [15:0]               o_stack_limit_reg,
   output logic                      o_trap_req,
   output logic                      o_stack_err
);
   import spl_pkg::*;

   // ==========================================
   // state
   // ==========================================
   typedef struct packed {
      logic [15:0] sp;
      spl_mem_t    mem;
      logic        trap;
      logic        err;
      logic        pc_hi;
      logic [15:0] pc_hi_word;
   } spl_state_t;

   spl_state_t state;
   spl_state_t next_state;
   logic [15:0] stack_limit_reg;
   logic [15:0] chk_addr;
   logic        chk_en;
   logic        over;
   logic        under;

   // pushed word for a return address upper part
   function automatic logic [15:0] pc_upper(input logic [22:0] pc, input logic [7:0] status_byte,
                                             input logic exc);
      logic [15:0] w;
      w = {9'h000, pc[22:16]};
      if (exc)
         w[15:8] = status_byte;
      return w;
   endfunction

   // ==========================================
   // limit register (no reset)
   // ==========================================
   // limit not reset
   always_ff @(posedge i_clk)
   begin
      if (i_limit_we)
         stack_limit_reg <= {i_limit_data[15:1], 1'b0};
   end

   // ==========================================
   // address check
   // ==========================================
   // every stack address checked
   always_comb
   begin
      chk_en   = 1'b1;
      chk_addr = state.sp;
      case (i_op)
         SPL_OP_PUSH, SPL_OP_CALL, SPL_OP_EXC: chk_addr = state.sp;
         SPL_OP_POP: chk_addr = state.sp - `SPL_WORD_STEP;
         SPL_OP_EA:  chk_addr = i_ea;
         default:    chk_en = state.pc_hi;
      endcase
      // second return word always checked at its own address
      if (state.pc_hi)
      begin
         chk_en   = 1'b1;
         chk_addr = state.sp;
      end
   end

   spl_cmp u_cmp
   (
      .i_addr  (chk_addr),
      .i_check (chk_en),
      .i_limit (stack_limit_reg),
      .o_over  (over),
      .o_under (under)
   );

   // ==========================================
   // next state
   // ==========================================
   always_comb
   begin
      next_state = state;
      next_state.mem = '0;
      next_state.trap = 1'b0;
      next_state.pc_hi = 1'b0;
      if (i_wreg.we && i_wreg.idx == `SPL_SP_INDEX)
         next_state.sp = {i_wreg.data[15:1], 1'b0};
      if (state.pc_hi)
      begin
         // second word of a return address push
         next_state.mem = '{valid: 1'b1, write: 1'b1, addr: state.sp, wdata: state.pc_hi_word};
         next_state.sp  = state.sp + `SPL_WORD_STEP;
      end
      else
      begin
         case (i_op)
            SPL_OP_PUSH:
            begin
               next_state.mem = '{valid: 1'b1, write: 1'b1, addr: state.sp, wdata: i_push_data};
               next_state.sp  = state.sp + `SPL_WORD_STEP;
            end
            SPL_OP_POP:
            begin
               next_state.sp  = state.sp - `SPL_WORD_STEP;
               next_state.mem = '{valid: 1'b1, write: 1'b0, addr: next_state.sp, wdata: 16'h0000};
            end
            // 23-bit pc split into two words
            SPL_OP_CALL, SPL_OP_EXC:
            begin
               next_state.mem = '{valid: 1'b1, write: 1'b1, addr: state.sp,
                                  wdata: {i_pc[15:1], 1'b0}};
               next_state.sp  = state.sp + `SPL_WORD_STEP;
               next_state.pc_hi = 1'b1;
               next_state.pc_hi_word = pc_upper(i_pc, i_status_low_byte, i_op == SPL_OP_EXC);
            end
            default:
            begin
            end
         endcase
      end
      if (over || under)
         next_state.trap = 1'b1;
      if (i_err_clr)
         next_state.err = 1'b0;
      if (over || under)
         next_state.err = 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state    <= '0;
         state.sp <= `SPL_SP_RESET;
      end
      else
         state <= next_state;
   end

   // ==========================================
   // outputs
   // ==========================================
   assign o_mem               = state.mem;
   assign o_stack_pointer_reg = state.sp;
   assign o_stack_limit_reg   = stack_limit_reg;
   assign o_trap_req          = state.trap;
   assign o_stack_err         = state.err;

   // ==========================================
   // checks
   // ==========================================
   a_push_inc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_PUSH && !state.pc_hi && !i_wreg.we)
      |=> (state.sp == $past(state.sp) + 16'h0002 && state.mem.addr == $past(state.sp)))
      else $error("push did not write then increment");
   a_pop_dec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_POP && !state.pc_hi && !i_wreg.we)
      |=> (state.mem.addr == state.sp && state.sp == $past(state.sp) - 16'h0002))
      else $error("pop did not decrement then read");
   a_limit_bit0: assert property (@(posedge i_clk)
      $past(i_limit_we) |-> !stack_limit_reg[0])
      else $error("limit bit zero set");
   a_over_trap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_PUSH && !state.pc_hi && state.sp > stack_limit_reg) |=> o_trap_req)
      else $error("push past limit did not trap");
   a_eq_notrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_PUSH && !state.pc_hi && state.sp == stack_limit_reg
       && state.sp >= 16'h0800) |=> !o_trap_req)
      else $error("push at limit trapped");
   a_under_trap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_POP && !state.pc_hi && state.sp < 16'h0802) |=> (o_trap_req && o_stack_err))
      else $error("underflow not flagged");
   a_call_msb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_CALL && !state.pc_hi) |=> ##1 (state.mem.write && !state.mem.wdata[15]))
      else $error("call push top bit set");
   a_exc_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_op == SPL_OP_EXC && !state.pc_hi)
      |=> ##1 (state.mem.wdata[15:8] == $past(i_status_low_byte, 2)))
      else $error("exception push lacks status byte");
   a_err_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_stack_err && !i_err_clr) |=> o_stack_err)
      else $error("stack error flag dropped");
   a_second_word: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      state.pc_hi |=> (state.mem.valid && state.mem.write && state.mem.addr == $past(state.sp)))
      else $error("second return word not written");
   a_err_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (over || under) |=> (o_trap_req && o_stack_err))
      else $error("stack error not raised");
endmodule

/* sim/test_spl_core.sv */
// self-checking testbench for the stack pointer limit checker
`timescale 1ns/1ps
module test_spl_core;
   import spl_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic             i_clk = 1'b0;
   logic             i_rst_n = 1'b0;
   spl_op_t          i_op = SPL_OP_NONE;
   logic [15:0]      i_push_data = 16'h0000;
   logic [22:0]      i_pc = 23'h000000;
   logic [7:0]       i_status_low_byte = 8'h00;
   logic [15:0]      i_ea = 16'h0000;
   spl_wreg_t        i_wreg = '0;
   logic             i_limit_we = 1'b0;
   logic [15:0]      i_limit_data = 16'h0000;
   logic             i_err_clr = 1'b0;
   spl_mem_t         o_mem;
   logic [15:0]      o_stack_pointer_reg;
   logic [15:0]      o_stack_limit_reg;
   logic             o_trap_req;
   logic             o_stack_err;
   int               errors = 0;
   int               checks_done = 0;
   always #2 i_clk = ~i_clk;
   spl_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_op(i_op), .i_push_data(i_push_data),
      .i_pc(i_pc), .i_status_low_byte(i_status_low_byte), .i_ea(i_ea), .i_wreg(i_wreg),
      .i_limit_we(i_limit_we), .i_limit_data(i_limit_data), .i_err_clr(i_err_clr),
      .o_mem(o_mem), .o_stack_pointer_reg(o_stack_pointer_reg),
      .o_stack_limit_reg(o_stack_limit_reg), .o_trap_req(o_trap_req), .o_stack_err(o_stack_err));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_mem(input logic w, input logic [15:0] a, input logic [15:0] d);
      chk(o_mem.valid, 1'b1, "access valid");
      chk(o_mem.write, w, "access direction");
      chk(o_mem.addr, a, "access address");
      if (w)
         chk(o_mem.wdata, d, "access data");
   endtask
   task automatic op(input spl_op_t o);
      i_op = o;
      @(negedge i_clk);
      i_op = SPL_OP_NONE;
   endtask
   task automatic set_limit(input logic [15:0] v);
      i_limit_we = 1'b1;
      i_limit_data = v;
      @(negedge i_clk);
      i_limit_we = 1'b0;
   endtask
   task automatic set_reg(input logic [3:0] idx, input logic [15:0] v);
      i_wreg = '{we: 1'b1, idx: idx, data: v};
      @(negedge i_clk);
      i_wreg = '0;
   endtask
   task automatic clear_err();
      i_err_clr = 1'b1;
      @(negedge i_clk);
      i_err_clr = 1'b0;
      chk(o_stack_err, 1'b0, "error flag cleared");
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset_limit();
      chk(o_stack_pointer_reg, 16'h0800, "reset pointer");
      chk({o_trap_req, o_stack_err, o_mem.valid}, 3'h0, "reset outputs");
      chk(o_stack_limit_reg, 16'hXXXX, "limit untouched by reset");
      set_limit(16'h0805);
      chk(o_stack_limit_reg, 16'h0804, "limit bit zero forced");
   endtask
   task automatic t_push_overflow();
      logic [15:0] s;
      s = 16'h0800;
      repeat (3)
      begin
         i_push_data = s ^ 16'hA5C3;
         op(SPL_OP_PUSH);
         chk_mem(1'b1, s, s ^ 16'hA5C3);
         chk(o_trap_req, 1'b0, "push up to limit");
         s = s + 16'h0002;
         chk(o_stack_pointer_reg, s, "pointer after push");
      end
      op(SPL_OP_PUSH);
      chk(o_trap_req, 1'b1, "push past limit");
      @(negedge i_clk);
      chk({o_trap_req, o_stack_err}, 2'b01, "single pulse, sticky flag");
      clear_err();
   endtask
   task automatic t_pop_underflow();
      set_reg(4'h3, 16'h0A00);
      chk(o_stack_pointer_reg, 16'h0808, "other register leaves pointer");
      set_reg(4'hF, 16'h0802);
      chk(o_stack_pointer_reg, 16'h0802, "pointer as working register");
      op(SPL_OP_POP);
      chk_mem(1'b0, 16'h0800, 16'h0000);
      chk({o_stack_pointer_reg, o_trap_req}, {16'h0800, 1'b0}, "pop to floor");
      op(SPL_OP_POP);
      chk({o_stack_pointer_reg, o_trap_req}, {16'h07FE, 1'b1}, "pop below floor");
      clear_err();
   endtask
   task automatic t_return_words();
      set_limit(16'hFFFE);
      set_reg(4'hF, 16'h0900);
      i_pc = 23'h5ABCD7;
      op(SPL_OP_CALL);
      chk_mem(1'b1, 16'h0900, 16'hBCD6);
      @(negedge i_clk);
      chk_mem(1'b1, 16'h0902, 16'h005A);
      i_pc = 23'h7F1235;
      i_status_low_byte = 8'hA5;
      op(SPL_OP_EXC);
      chk_mem(1'b1, 16'h0904, 16'h1234);
      @(negedge i_clk);
      chk_mem(1'b1, 16'h0906, 16'hA57F);
      chk(o_stack_pointer_reg, 16'h0908, "pointer after return words");
      chk(o_stack_err, 1'b0, "no error in range");
   endtask
   task automatic t_ea_check();
      logic [15:0] ea [3];
      logic        tr [3];
      ea = '{16'h0902, 16'h0900, 16'h07FE};
      tr = '{1'b1, 1'b0, 1'b1};
      set_limit(16'h0900);
      @(negedge i_clk); // idle cycle after limit write
      for (int k = 0; k < 3; k++)
      begin
         i_ea = ea[k];
         op(SPL_OP_EA);
         chk(o_trap_req, tr[k], "address checked against bounds");
      end
   endtask
   // ==========================================================
   // verdict and run control
   task automatic wrap_up();
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #(4 * 2000);
      errors++;
      wrap_up();
   end
   initial
   begin
      repeat (3) @(negedge i_clk);
      i_rst_n = 1'b1;
      t_reset_limit();
      t_push_overflow();
      t_pop_underflow();
      t_return_words();
      t_ea_check();
      wrap_up();
   end
endmodule
